// ==== src/aofpc_pkg.sv ====
package aofpc_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int SAMPLE_W  = 14;
    localparam int HALF_W    = 7;
    localparam int CHANNELS  = 2;

    // ------------------------------------------------------------
    // register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_OUTPUT_MODE = 12'h0073 << 2;
    localparam logic [11:0] ADDR_POWER_CTRL  = 12'h0004;
    localparam logic [11:0] ADDR_DIVIDER     = 12'h0008;
    localparam logic [11:0] ADDR_STATUS      = 12'h000C;

    // output mode fields
    localparam int FMT_LSB      = 0;
    localparam int STYLE_BIT    = 2;
    localparam int DRIVE_BIT    = 3;
    // override fields
    localparam int OVR_BIT      = 2;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        AOFPC_FMT_TWOS   = 2'h0,
        AOFPC_FMT_GRAY   = 2'h1,
        AOFPC_FMT_OFFSET = 2'h2
    } aofpc_format_type;

    typedef enum logic [1:0] {
        AOFPC_PWR_NORMAL = 2'h0,
        AOFPC_PWR_NAP    = 2'h1,
        AOFPC_PWR_SLEEP  = 2'h2
    } aofpc_power_type;

    typedef enum logic [1:0] {
        AOFPC_DIV_1 = 2'h0,
        AOFPC_DIV_2 = 2'h1,
        AOFPC_DIV_4 = 2'h2
    } aofpc_div_type;

    // tri-level pin seen as two comparator levels
    typedef struct packed {
        logic high;
        logic low;
    } aofpc_trilevel_type;

    typedef struct packed {
        aofpc_format_type format;
        logic             style_cmos;
        logic             drive_low;
    } aofpc_outmode_type;

    localparam logic [31:0] OUTMODE_RESET = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 10;
    localparam int DLL_RELOCK_US   = 52;
    localparam int DLL_RELOCK_CYC  = (DLL_RELOCK_US * 1000) / CLK_PERIOD_NS;

endpackage

// ==== src/aofpc_top.sv ====
// ------------------------------------------------------------
// ------------------------------------------------------------
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module aofpc_top
    import aofpc_pkg::*;
#(
    parameter int RELOCK_CYCLES = DLL_RELOCK_CYC
)(
    input  wire logic                                 clk,
    input  wire logic                                 nrst,
    input  wire logic                                 psel,
    input  wire logic                                 penable,
    input  wire logic                                 pwrite,
    input  wire logic [11:0]                          paddr,
    input  wire logic [31:0]                          pwdata,
    output logic      [31:0]                          prdata,
    output logic                                      pready,
    output logic                                      pslverr,
    input  wire logic [CHANNELS*SAMPLE_W-1:0]         sample_in,
    input  wire logic                                 over_range_in,
    input  wire logic                                 clock_present,
    input  wire logic                                 power_state_pin_high,
    input  wire logic                                 power_state_pin_low,
    input  wire logic                                 divide_ratio_pin_high,
    input  wire logic                                 divide_ratio_pin_low,
    input  wire logic                                 divider_sync_reset_pos,
    input  wire logic                                 divider_sync_reset_neg,
    input  wire logic                                 phase_seed,
    output logic      [CHANNELS*HALF_W-1:0]           data_out,
    output logic                                      data_oe,
    output logic                                      over_range_out,
    output logic                                      forwarded_clock_pos,
    output logic                                      forwarded_clock_neg,
    output logic                                      clock_oe,
    output logic                                      style_cmos,
    output logic                                      drive_low,
    output logic                                      sample_strobe,
    output logic                                      ready_out
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 7;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    logic             pwr_hi_s;
    logic             pwr_lo_s;
    logic             div_hi_s;
    logic             div_lo_s;
    logic             rst_pos_s;
    logic             rst_neg_s;
    logic             clk_ok_s;
    logic [NSYNC-1:0] pin_raw;

    assign pin_raw = {clock_present, divider_sync_reset_neg, divider_sync_reset_pos,
                      divide_ratio_pin_low, divide_ratio_pin_high,
                      power_state_pin_low, power_state_pin_high};

    // two flops per pin, only the second is read
    genvar sb;
    generate
        for (sb = 0; sb < NSYNC; sb++) begin : g_sync
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    sync_a[sb] <= 1'b0;
                    sync_b[sb] <= 1'b0;
                end else begin
                    sync_a[sb] <= pin_raw[sb];
                    sync_b[sb] <= sync_a[sb];
                end
            end
        end
    endgenerate

    assign {clk_ok_s, rst_neg_s, rst_pos_s, div_lo_s, div_hi_s, pwr_lo_s, pwr_hi_s} = sync_b;

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    aofpc_outmode_type outmode;
    logic              pwr_ovr;
    aofpc_power_type   pwr_sw;
    logic              div_ovr;
    aofpc_div_type     div_sw;
    logic              wr_en;
    logic              wr_mode;
    logic              wr_pwr;
    logic              wr_div;

    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en   = psel && penable && pwrite;
    assign wr_mode = wr_en && (paddr == ADDR_OUTPUT_MODE);
    assign wr_pwr  = wr_en && (paddr == ADDR_POWER_CTRL);
    assign wr_div  = wr_en && (paddr == ADDR_DIVIDER);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            outmode <= aofpc_outmode_type'(OUTMODE_RESET[3:0]);
        end else if (wr_mode) begin
            outmode.format     <= aofpc_format_type'(pwdata[FMT_LSB+:2]);
            outmode.style_cmos <= pwdata[STYLE_BIT];
            outmode.drive_low  <= pwdata[DRIVE_BIT];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pwr_ovr <= 1'b0;
            pwr_sw  <= AOFPC_PWR_NORMAL;
        end else if (wr_pwr) begin
            pwr_sw  <= aofpc_power_type'(pwdata[1:0]);
            pwr_ovr <= pwdata[OVR_BIT];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_ovr <= 1'b0;
            div_sw  <= AOFPC_DIV_1;
        end else if (wr_div) begin
            div_sw  <= aofpc_div_type'(pwdata[1:0]);
            div_ovr <= pwdata[OVR_BIT];
        end
    end

    // ------------------------------------------------------------
    // power and divider selection
    // ------------------------------------------------------------
    aofpc_power_type pwr_pin;
    aofpc_power_type pwr_mode;
    aofpc_div_type   div_pin;
    aofpc_div_type   div_mode;

    always_comb begin
        if (pwr_lo_s)
            pwr_pin = AOFPC_PWR_NORMAL;
        else if (pwr_hi_s)
            pwr_pin = AOFPC_PWR_NAP;
        else
            pwr_pin = AOFPC_PWR_SLEEP;
        if (div_lo_s)
            div_pin = AOFPC_DIV_2;
        else if (div_hi_s)
            div_pin = AOFPC_DIV_4;
        else
            div_pin = AOFPC_DIV_1;
    end

    assign pwr_mode = pwr_ovr ? pwr_sw : pwr_pin;
    assign div_mode = div_ovr ? div_sw : div_pin;

    logic powered_down;
    assign powered_down = (pwr_mode != AOFPC_PWR_NORMAL);

    // ------------------------------------------------------------
    // dll relock after clock loss in nap or sleep
    // ------------------------------------------------------------
    logic        clk_lost;
    logic [31:0] relock_cnt;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            clk_lost <= 1'b0;
        end else if (powered_down && !clk_ok_s) begin
            clk_lost <= 1'b1;
        end else if (!powered_down) begin
            clk_lost <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            relock_cnt <= '0;
        end else if (powered_down) begin
            relock_cnt <= clk_lost ? 32'(RELOCK_CYCLES) : '0;
        end else if (relock_cnt != '0) begin
            relock_cnt <= relock_cnt - 32'h0000_0001;
        end
    end

    assign ready_out = !powered_down && relock_cnt == '0;

    // ------------------------------------------------------------
    // clock divider with synchronous realign
    // ------------------------------------------------------------
    // counts in half-word steps
    logic [2:0] div_cnt;
    logic       phase_init;
    logic       div_rst;
    logic       div_rst_d;
    logic       sample_tick;

    // true-pair check on the reset legs
    assign div_rst = rst_pos_s && !rst_neg_s;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_rst_d  <= 1'b0;
            phase_init <= 1'b0;
        end else begin
            div_rst_d  <= div_rst;
            phase_init <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_cnt <= '0;
        end else if (!phase_init) begin
            div_cnt <= {1'b0, phase_seed, 1'b0};
        end else if (div_rst && !div_rst_d && div_mode != AOFPC_DIV_1) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 3'h1;
        end
    end

    always_comb begin
        case (div_mode)
            // one word takes two clocks, one per half
            AOFPC_DIV_1: sample_tick = (div_cnt[0] == 1'b1);
            AOFPC_DIV_2: sample_tick = (div_cnt[1:0] == 2'h3);
            AOFPC_DIV_4: sample_tick = (div_cnt == 3'h7);
            default:     sample_tick = (div_cnt[0] == 1'b1);
        endcase
    end

    // ------------------------------------------------------------
    // coding, applied at word boundary
    // ------------------------------------------------------------
    aofpc_format_type           fmt_live;
    logic [CHANNELS*SAMPLE_W-1:0] coded;
    logic [CHANNELS*SAMPLE_W-1:0] word_reg;
    logic                       half_sel;
    logic                       or_reg;

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_code
            logic [SAMPLE_W-1:0] ob;
            assign ob = sample_in[ch*SAMPLE_W+:SAMPLE_W];
            always_comb begin
                case (fmt_live)
                    AOFPC_FMT_OFFSET: coded[ch*SAMPLE_W+:SAMPLE_W] = ob;
                    AOFPC_FMT_GRAY:   coded[ch*SAMPLE_W+:SAMPLE_W] = ob ^ (ob >> 1);
                    default:          coded[ch*SAMPLE_W+:SAMPLE_W] =
                                          {~ob[SAMPLE_W-1], ob[SAMPLE_W-2:0]};
                endcase
            end
        end
    endgenerate

    // format switches only between words
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fmt_live <= AOFPC_FMT_TWOS;
        end else if (sample_tick) begin
            fmt_live <= outmode.format;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            word_reg <= '0;
            or_reg   <= 1'b0;
        end else if (sample_tick) begin
            word_reg <= coded;
            or_reg   <= over_range_in;
        end
    end

    // ------------------------------------------------------------
    // ddr launch and forwarded clock
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            half_sel <= 1'b0;
        end else if (sample_tick) begin
            half_sel <= 1'b0;
        end else begin
            half_sel <= 1'b1;
        end
    end

    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_ddr
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    data_out[ch*HALF_W+:HALF_W] <= '0;
                end else begin
                    data_out[ch*HALF_W+:HALF_W] <= half_sel ?
                        word_reg[ch*SAMPLE_W+HALF_W+:HALF_W] :
                        word_reg[ch*SAMPLE_W+:HALF_W];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            forwarded_clock_pos <= 1'b0;
            forwarded_clock_neg <= 1'b1;
        end else begin
            forwarded_clock_pos <= half_sel;
            forwarded_clock_neg <= !half_sel;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            over_range_out      <= 1'b0;
            sample_strobe       <= 1'b0;
        end else begin
            over_range_out      <= or_reg;
            sample_strobe       <= sample_tick;
        end
    end

    assign data_oe    = !powered_down;
    assign clock_oe   = !powered_down;
    assign style_cmos = outmode.style_cmos;
    assign drive_low  = !outmode.style_cmos && outmode.drive_low;

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    logic [31:0] status_word;

    assign status_word = {27'h000_0000, ready_out, pwr_mode, div_mode};

    always_comb begin
        case (paddr)
            ADDR_OUTPUT_MODE: prdata = {28'h000_0000, outmode.drive_low, outmode.style_cmos, outmode.format};
            ADDR_POWER_CTRL:  prdata = {29'h0000_0000, pwr_ovr, pwr_sw};
            ADDR_DIVIDER:     prdata = {29'h0000_0000, div_ovr, div_sw};
            ADDR_STATUS:      prdata = status_word;
            default:          prdata = UNMAPPED_DATA;
        endcase
    end

endmodule

`default_nettype wire

// ==== tb/aofpc_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module aofpc_properties
    import aofpc_pkg::*;
#(
    parameter int RELOCK_CYCLES = 8
)(
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        clock_present,
    input wire logic        divider_sync_reset_pos,
    input wire logic        data_oe,
    input wire logic        clock_oe,
    input wire logic        forwarded_clock_pos,
    input wire logic        forwarded_clock_neg,
    input wire logic        style_cmos,
    input wire logic        drive_low,
    input wire logic        ready_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic wr_mode;
    logic wr_pwr;
    assign wr_mode = psel && penable && pwrite && paddr == ADDR_OUTPUT_MODE;
    assign wr_pwr  = psel && penable && pwrite && paddr == ADDR_POWER_CTRL;
    diff_clock_a: assert property (clock_oe |-> forwarded_clock_neg == !forwarded_clock_pos)
        else $error("output clock legs not complementary");
    oe_together_a: assert property (data_oe == clock_oe)
        else $error("data and clock enables differ");
    ready_power_a: assert property (ready_out |-> data_oe)
        else $error("ready while outputs off");
    apb_ready_a: assert property (psel && penable |-> pready && !pslverr)
        else $error("access phase not answered cleanly");
    mode_write_a: assert property (wr_mode |=> style_cmos == $past(pwdata[STYLE_BIT])
        && drive_low == ($past(pwdata[DRIVE_BIT]) && !$past(pwdata[STYLE_BIT])))
        else $error("output mode write lost");
    mode_hold_a: assert property (!wr_mode |=> $stable({style_cmos, drive_low}))
        else $error("output mode changed without write");
    nap_write_a: assert property (wr_pwr && pwdata[OVR_BIT] && pwdata[1:0] != 2'h0
        && pwdata[1:0] != 2'h3 |=> !data_oe) else $error("power override ignored");
    relock_a: assert property ($rose(clock_present) && !data_oe |-> !ready_out [*4])
        else $error("ready before relock");
    cover property (wr_mode);
    cover property ($fell(data_oe));
    cover property ($rose(divider_sync_reset_pos));
    cover property ($rose(ready_out));
endmodule
bind aofpc_top aofpc_properties #(.RELOCK_CYCLES(RELOCK_CYCLES)) i_aofpc_properties (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .clock_present(clock_present),
    .divider_sync_reset_pos(divider_sync_reset_pos), .data_oe(data_oe), .clock_oe(clock_oe),
    .forwarded_clock_pos(forwarded_clock_pos), .forwarded_clock_neg(forwarded_clock_neg),
    .style_cmos(style_cmos), .drive_low(drive_low), .ready_out(ready_out)
);
`default_nettype wire

// ==== tb/aofpc_capture.sv ====
`timescale 1ns/1ps
`default_nettype none
module aofpc_capture
    import aofpc_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic [CHANNELS*HALF_W-1:0] data_out,
    input  wire logic                       clk_pos,
    output logic      [SAMPLE_W-1:0]        word_a,
    output logic      [SAMPLE_W-1:0]        word_b,
    output logic      [SAMPLE_W-1:0]        gray_back
);
    logic [CHANNELS*HALF_W-1:0] low_half;
    // low half on low clock phase, high half on high phase
    always_ff @(posedge clk) begin
        if (!clk_pos) begin
            low_half <= data_out;
        end else begin
            word_a <= {data_out[HALF_W-1:0], low_half[HALF_W-1:0]};
            word_b <= {data_out[2*HALF_W-1:HALF_W], low_half[2*HALF_W-1:HALF_W]};
        end
    end
    always_comb begin
        gray_back[SAMPLE_W-1] = word_a[SAMPLE_W-1];
        for (int i = SAMPLE_W - 2; i >= 0; i--) begin
            gray_back[i] = word_a[i] ^ gray_back[i + 1];
        end
    end
endmodule
`default_nettype wire

// ==== tb/aofpc_top_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module aofpc_top_test;
    import aofpc_pkg::*;
    logic        clk, nrst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, wd;
    logic [27:0] sample_in;
    logic [13:0] data_out, v, word_a, word_b, gray_back;
    logic        over_range_in, clock_present, pwr_hi, pwr_lo, div_hi, div_lo;
    logic        sync_p, sync_n, phase_seed, data_oe, over_range_out, fclk_p, fclk_n;
    logic        clock_oe, style_cmos, drive_low, sample_strobe, ready_out;
    logic [13:0] corner [5] = '{14'h0000, 14'h0001, 14'h2000, 14'h3ffe, 14'h3fff};
    logic [1:0]  pin_tab [3] = '{2'b10, 2'b00, 2'b01};
    aofpc_power_type pwr_tab [3] = '{AOFPC_PWR_NORMAL, AOFPC_PWR_SLEEP, AOFPC_PWR_NAP};
    integer      seed = 32'hbe0c_a2c0;
    int          error_cnt = 0, cmp_count = 0, g1, g2, c [4];

    aofpc_top #(.RELOCK_CYCLES(8)) i_aofpc_top (
        .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_in(sample_in), .over_range_in(over_range_in), .clock_present(clock_present),
        .power_state_pin_high(pwr_hi), .power_state_pin_low(pwr_lo),
        .divide_ratio_pin_high(div_hi), .divide_ratio_pin_low(div_lo),
        .divider_sync_reset_pos(sync_p), .divider_sync_reset_neg(sync_n), .phase_seed(phase_seed),
        .data_out(data_out), .data_oe(data_oe), .over_range_out(over_range_out),
        .forwarded_clock_pos(fclk_p), .forwarded_clock_neg(fclk_n), .clock_oe(clock_oe),
        .style_cmos(style_cmos), .drive_low(drive_low), .sample_strobe(sample_strobe),
        .ready_out(ready_out)
    );
    aofpc_capture i_aofpc_capture (
        .clk(clk), .data_out(data_out), .clk_pos(fclk_p), .word_a(word_a), .word_b(word_b),
        .gray_back(gray_back)
    );
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [13:0] code(input logic [1:0] f, input logic [13:0] b);
        case (f)
            AOFPC_FMT_GRAY:   code = b ^ (b >> 1);
            AOFPC_FMT_OFFSET: code = b;
            default:          code = b ^ 14'h2000;
        endcase
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    task automatic strobes(output int n);
        n = 0;
        repeat (8) @(posedge clk);
        repeat (64) begin
            @(posedge clk);
            n += (sample_strobe === 1'b1);
        end
    endtask
    task automatic sync_gap(input int d, output int g);
        repeat (d) @(posedge clk);
        sync_p <= 1;
        sync_n <= 0;
        repeat (2) @(posedge clk);
        sync_p <= 0;
        sync_n <= 1;
        repeat (10) @(posedge clk);
        g = 0;
        while (sample_strobe !== 1'b1 && g < 40) begin
            @(posedge clk);
            g++;
        end
    endtask
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        end_of_test;
    end
    initial begin
        {psel, penable, pwrite, over_range_in, pwr_hi, div_hi, div_lo, sync_p} = '0;
        {clock_present, pwr_lo, sync_n, nrst} = 4'b1110;
        paddr = '0;
        pwdata = '0;
        sample_in = '0;
        phase_seed = $random(seed);
        repeat (4) @(posedge clk);
        nrst <= 1;
        repeat (4) @(posedge clk);
        apb(0, ADDR_OUTPUT_MODE, 0);
        check("out_mode", rd, OUTMODE_RESET);
        check("style_drive", {style_cmos, drive_low}, 0);
        apb(1, 12'h010, 32'hffff_ffff);
        apb(0, 12'h010, 0);
        check("unmapped", rd, UNMAPPED_DATA);
        for (int f = 0; f < 3; f++) begin
            for (int k = 0; k < 8; k++) begin
                v = (k < 5) ? corner[k] : 14'($random(seed));
                sample_in <= {~v, v};
                over_range_in <= $random(seed);
                wd = {28'h0, 2'($random(seed)), 2'(f)};
                apb(1, ADDR_OUTPUT_MODE, wd);
                check("style", style_cmos, wd[STYLE_BIT]);
                check("drive", drive_low, wd[DRIVE_BIT] && !wd[STYLE_BIT]);
                repeat (12) @(posedge clk);
                check("word_a", word_a, code(2'(f), v));
                check("word_b", word_b, code(2'(f), ~v));
                if (f == 1) check("gray_back", gray_back, v);
                check("over_range", over_range_out, over_range_in);
            end
        end
        // input clock kept running through every power state
        for (int p = 0; p < 3; p++) begin
            {pwr_lo, pwr_hi} <= pin_tab[p];
            repeat (4) @(posedge clk);
            apb(0, ADDR_STATUS, 0);
            check("pin_power", rd[3:2], pwr_tab[p]);
            check("pin_oe", {data_oe, clock_oe}, (p == 0) ? 2'b11 : 2'b00);
        end
        apb(1, ADDR_POWER_CTRL, 32'h0000_0004);
        check("ovr_normal", {data_oe, clock_oe}, 2'b11);
        apb(1, ADDR_POWER_CTRL, 32'h0000_0005);
        check("ovr_nap", {data_oe, clock_oe}, 2'b00);
        clock_present <= 0;
        repeat (6) @(posedge clk);
        clock_present <= 1;
        apb(1, ADDR_POWER_CTRL, 32'h0000_0004);
        check("relock_wait", ready_out, 0);
        for (int n = 0; n < 40 && ready_out !== 1'b1; n++) @(posedge clk);
        check("relock_done", ready_out, 1);
        for (int d = 0; d < 3; d++) begin
            apb(1, ADDR_DIVIDER, 32'h0000_0004 | d);
            strobes(c[d]);
        end
        check("strobes", c[0] > 0, 1);
        check("div2", c[1] * 2, c[0]);
        check("div4", c[2] * 4, c[0]);
        apb(1, ADDR_DIVIDER, 0);
        for (int q = 1; q < 3; q++) begin
            {div_lo, div_hi} <= (q == 1) ? 2'b10 : 2'b01;
            strobes(c[3]);
            check("div_pin", c[3] << q, c[0]);
        end
        sync_gap(2, g1);
        sync_gap(3, g2);
        check("sync_phase", g1, g2);
        end_of_test;
    end
endmodule
`default_nettype wire
